// ==== verilog/bpdb_pkg.sv ====
package bpdb_pkg;
  // register offsets
  localparam logic [7:0] BPDB_OFF_DATA = 8'h00;
  localparam logic [7:0] BPDB_OFF_DIR  = 8'h02;
  localparam logic [7:0] BPDB_OFF_FUNC = 8'h03;
  // widths and reset values
  localparam int         BPDB_WIDTH     = 8;
  localparam logic [7:0] BPDB_RST_DATA  = 8'h00;
  localparam logic [7:0] BPDB_RST_DIR   = 8'h00;
  localparam logic       BPDB_RST_FUNC  = 1'b0;
  localparam int         BPDB_FUNC_BIT  = 0;
  localparam logic [7:0] BPDB_RD_ZERO   = 8'h00;
endpackage : bpdb_pkg

// ==== verilog/bpdb_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
module bpdb_sync
  import bpdb_pkg::*;
(
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_b,
  input  wire logic [BPDB_WIDTH-1:0] i_async,
  output logic      [BPDB_WIDTH-1:0] o_sync
);
  import bpdb_pkg::*;

  typedef struct packed
  {
    logic [BPDB_WIDTH-1:0] stage1;
    logic [BPDB_WIDTH-1:0] stage2;
  } bpdb_sync_state_type;

  bpdb_sync_state_type state_reg;
  bpdb_sync_state_type state_next;

  // first stage is read only by the second stage
  always_comb
  begin
    state_next        = state_reg;
    state_next.stage1 = i_async;
    state_next.stage2 = state_reg.stage1;
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign o_sync = state_reg.stage2;
endmodule : bpdb_sync
`default_nettype wire

// ==== verilog/bpdb_pin_cell.sv ====
`timescale 1ns/10ps
`default_nettype none
module bpdb_pin_cell
(
  input  wire logic i_bus_mode,
  input  wire logic i_bus_drive,
  input  wire logic i_bus_data,
  input  wire logic i_dir_out,
  input  wire logic i_port_data,
  output logic      o_pin,
  output logic      o_pin_oe_b
);
  // bus mode ignores the direction bit entirely
  always_comb
  begin
    if (i_bus_mode)
    begin
      o_pin      = i_bus_data;
      o_pin_oe_b = ~i_bus_drive;
    end
    else
    begin
      o_pin      = i_port_data;
      o_pin_oe_b = ~i_dir_out;
    end
  end
endmodule : bpdb_pin_cell
`default_nettype wire

// ==== verilog/bpdb_port.sv ====
// Notes on behaviour
// - eight port pins, each general purpose, one data register bit per pin.
// - each direction bit picks input (0) or output (1) for its pin.
// - function bit 1 hands all pins to the external data lines; 0 is port.
// - in bus mode direction bits are ignored; the bus controls the pins.
`timescale 1ns/10ps
`default_nettype none
module bpdb_port
  import bpdb_pkg::*;
(
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_b,
  input  wire logic [7:0]            i_addr,
  input  wire logic [7:0]            i_wdata,
  input  wire logic                  i_wr,
  input  wire logic                  i_rd,
  output logic      [7:0]            o_rdata,
  input  wire logic [BPDB_WIDTH-1:0] i_ext_wdata,
  input  wire logic                  i_ext_drive,
  output logic      [BPDB_WIDTH-1:0] o_ext_rdata,
  output logic                       o_bus_mode,
  input  wire logic [BPDB_WIDTH-1:0] i_port_pins,
  output logic      [BPDB_WIDTH-1:0] o_port_pins,
  output logic      [BPDB_WIDTH-1:0] o_port_pins_oe_b
);
  import bpdb_pkg::*;

  // ==========================================================
  // state
  typedef struct packed
  {
    logic [BPDB_WIDTH-1:0] data;
    logic [BPDB_WIDTH-1:0] dir;
    logic                  func;
    logic [7:0]            rdata;
  } bpdb_state_type;

  bpdb_state_type        state_reg;
  bpdb_state_type        state_next;
  logic [BPDB_WIDTH-1:0] pins_sync;
  logic [BPDB_WIDTH-1:0] data_view;

  // ==========================================================
  // pin input synchroniser
  bpdb_sync u_sync
  (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_async (i_port_pins),
    .o_sync  (pins_sync)
  );

  // read view mixes pins
  // output bits read back the latch, input bits the pin level
  assign data_view = (state_reg.data & state_reg.dir) | (pins_sync & ~state_reg.dir);

  // ==========================================================
  // register file
  always_comb
  begin
    state_next       = state_reg;
    state_next.rdata = BPDB_RD_ZERO;
    if (i_wr && i_addr == BPDB_OFF_DATA)
      state_next.data = i_wdata;
    if (i_wr && i_addr == BPDB_OFF_DIR)
      state_next.dir = i_wdata;
    if (i_wr && i_addr == BPDB_OFF_FUNC)
      state_next.func = i_wdata[BPDB_FUNC_BIT];
    // direction and function are write only, so they read as zero
    if (i_rd && i_addr == BPDB_OFF_DATA)
      state_next.rdata = data_view;
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state_reg.data  <= BPDB_RST_DATA;
      state_reg.dir   <= BPDB_RST_DIR;
      state_reg.func  <= BPDB_RST_FUNC;
      state_reg.rdata <= BPDB_RD_ZERO;
    end
    else
      state_reg <= state_next;
  end

  assign o_rdata     = state_reg.rdata;
  assign o_bus_mode  = state_reg.func;
  assign o_ext_rdata = pins_sync;

  // ==========================================================
  // pin drivers
  // per-pin mode mux
  for (genvar g = 0; g < BPDB_WIDTH; g++)
  begin : g_pin
    bpdb_pin_cell u_cell
    (
      .i_bus_mode  (state_reg.func),
      .i_bus_drive (i_ext_drive),
      .i_bus_data  (i_ext_wdata[g]),
      .i_dir_out   (state_reg.dir[g]),
      .i_port_data (state_reg.data[g]),
      .o_pin       (o_port_pins[g]),
      .o_pin_oe_b  (o_port_pins_oe_b[g])
    );
  end

  // ==========================================================
  // checks
  // output drives data
  a_port_out_drive: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !state_reg.func |-> ((o_port_pins & state_reg.dir) == (state_reg.data & state_reg.dir)))
    else $error("port output pin differs from data bit");
  a_dir_oe_map: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !state_reg.func |-> (o_port_pins_oe_b == ~state_reg.dir))
    else $error("pin enable does not follow direction");
  a_bus_oe_map: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    state_reg.func |-> (o_port_pins_oe_b == {BPDB_WIDTH{~i_ext_drive}}))
    else $error("bus mode enable wrong");
  a_func_write: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_wr && i_addr == BPDB_OFF_FUNC) |=> (o_bus_mode == $past(i_wdata[BPDB_FUNC_BIT])))
    else $error("function bit not written");
  a_data_read: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_rd && i_addr == BPDB_OFF_DATA) |=> (o_rdata == $past(data_view)))
    else $error("data read wrong");
  a_bus_pass: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    state_reg.func |-> (o_port_pins == i_ext_wdata))
    else $error("bus data not on pins");

  // ==========================================================
  // sequences
  // a strobe with no decoded target is simply dropped by the file
  sequence s_data_write;
    i_wr && (i_addr == BPDB_OFF_DATA);
  endsequence

  sequence s_dir_write;
    i_wr && (i_addr == BPDB_OFF_DIR);
  endsequence

  sequence s_func_write;
    i_wr && (i_addr == BPDB_OFF_FUNC);
  endsequence

  sequence s_data_read;
    i_rd && (i_addr == BPDB_OFF_DATA);
  endsequence

  sequence s_other_read;
    i_rd && (i_addr != BPDB_OFF_DATA);
  endsequence

  // two edges inside reset, so the flops have settled once
  sequence s_in_reset;
    !i_rst_b ##1 !i_rst_b;
  endsequence

  // ==========================================================
  // register write checks
  // data write lands
  a_data_write: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_data_write
    |=> (state_reg.data == $past(i_wdata)))
    else $error("data register not written");

  a_data_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !(i_wr && (i_addr == BPDB_OFF_DATA))
    |=> $stable(state_reg.data))
    else $error("data register changed without write");

  a_data_only: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_data_write
    |=> ($stable(state_reg.dir) && $stable(state_reg.func)))
    else $error("data write disturbed other registers");

  a_dir_write: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_dir_write
    |=> (state_reg.dir == $past(i_wdata)))
    else $error("direction register not written");

  a_dir_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !(i_wr && (i_addr == BPDB_OFF_DIR))
    |=> $stable(state_reg.dir))
    else $error("direction changed without write");

  a_dir_only: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_dir_write
    |=> ($stable(state_reg.data) && $stable(state_reg.func)))
    else $error("direction write disturbed other registers");

  a_func_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !(i_wr && (i_addr == BPDB_OFF_FUNC))
    |=> $stable(state_reg.func))
    else $error("function bit changed without write");

  a_func_only: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_func_write
    |=> ($stable(state_reg.data) && $stable(state_reg.dir)))
    else $error("function write disturbed other registers");

  // ==========================================================
  // read checks
  // no read gives zero
  a_rdata_idle: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !i_rd
    |=> (o_rdata == BPDB_RD_ZERO))
    else $error("read data without a read");

  a_read_once: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_data_read ##1 !i_rd
    |=> (o_rdata == BPDB_RD_ZERO))
    else $error("read data stood too long");

  a_wo_read_zero: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_other_read
    |=> (o_rdata == BPDB_RD_ZERO))
    else $error("write only or unmapped read not zero");

  a_in_bit_read: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_data_read
    |=> ((o_rdata & ~$past(state_reg.dir)) == ($past(pins_sync) & ~$past(state_reg.dir))))
    else $error("input bit read not pin level");

  a_out_bit_read: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_data_read
    |=> ((o_rdata & $past(state_reg.dir)) == ($past(state_reg.data) & $past(state_reg.dir))))
    else $error("output bit read not data latch");

  // ==========================================================
  // pin checks
  // port drives latch
  // input pins still carry the latch value so that a later turn to output
  // shows no glitch of stale data
  a_port_out_latch: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !state_reg.func
    |-> (o_port_pins == state_reg.data))
    else $error("port pins not from data latch");

  a_bus_drive_on: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (state_reg.func && i_ext_drive)
    |-> (o_port_pins_oe_b == '0))
    else $error("bus drive did not enable pins");

  a_bus_drive_off: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (state_reg.func && !i_ext_drive)
    |-> (o_port_pins_oe_b == '1))
    else $error("bus release left a pin driven");

  a_bus_enter: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $rose(state_reg.func)
    |-> (o_port_pins == i_ext_wdata))
    else $error("bus mode entry without bus data");

  a_port_exit: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $fell(state_reg.func)
    |-> (o_port_pins_oe_b == ~state_reg.dir))
    else $error("port mode exit without direction");

  // ==========================================================
  // reset checks
  // reset releases pins
  a_reset_idle: assert property (@(posedge i_clk)
    s_in_reset
    |-> ((o_port_pins_oe_b == '1) && (o_bus_mode == BPDB_RST_FUNC)))
    else $error("pins driven during reset");

  a_reset_regs: assert property (@(posedge i_clk)
    s_in_reset
    |-> ((state_reg.data == BPDB_RST_DATA) && (o_rdata == BPDB_RD_ZERO)))
    else $error("registers not cleared in reset");
endmodule : bpdb_port
`default_nettype wire

// ==== verification/bpdb_pin_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// pins the port releases are held at the outside pattern
module bpdb_pin_model
(
  input  wire logic [7:0] i_pins,
  input  wire logic [7:0] i_oe_b,
  input  wire logic [7:0] i_pattern,
  output logic      [7:0] o_level
);
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      o_level[i] = i_oe_b[i] ? i_pattern[i] : i_pins[i];
    end
  end
endmodule : bpdb_pin_model
`default_nettype wire

// ==== verification/bpdb_port_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module bpdb_port_tb;
  import bpdb_pkg::*;
  logic       clk = 0, rst_b = 0, wr = 0, rd = 0, drv = 0;
  logic [7:0] addr = 8'h00, wd = 8'h00, ewd = 8'h00, pat = 8'h00;
  logic [7:0] rdata, erd, pins, oe_b, lvl;
  logic       bmode;
  int         error_cnt = 0, check_count = 0;
  always #50 clk = ~clk;
  bpdb_port DUT (.i_clk(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wd), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_ext_wdata(ewd), .i_ext_drive(drv), .o_ext_rdata(erd),
    .o_bus_mode(bmode), .i_port_pins(lvl), .o_port_pins(pins), .o_port_pins_oe_b(oe_b));
  bpdb_pin_model PM (.i_pins(pins), .i_oe_b(oe_b), .i_pattern(pat), .o_level(lvl));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) begin wr <= 1; addr <= a; wd <= d; end
    @(posedge clk) wr <= 0;
    #1;
  endtask : wreg
  task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk) begin rd <= 1; addr <= a; end
    @(posedge clk) rd <= 0;
    #1 chk(rdata, exp);
  endtask : rreg
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  // ==========
  // watchdog at 3000 cycles: whole run is well under that
  initial
  begin
    #(3000 * 100);
    error_cnt++;
    complete_run();
  end
  // ==========
  // tests
  initial
  begin
    repeat (20) @(posedge clk);
    rst_b <= 1;
    #1 chk(oe_b, 8'hFF);
    chk({7'h00, bmode}, 8'h00);
    rreg(BPDB_OFF_DATA, 8'h00);
    $display("test 1 done");
    wreg(BPDB_OFF_DIR, 8'hFF);
    wreg(BPDB_OFF_DATA, 8'hA5);
    chk(oe_b, 8'h00);
    chk(pins, 8'hA5);
    rreg(BPDB_OFF_DATA, 8'hA5);
    @(posedge clk) pat <= 8'h3C;
    wreg(BPDB_OFF_DIR, 8'h0F);
    chk(oe_b, 8'hF0);
    repeat (3) @(posedge clk);
    // inputs show the outside level, outputs the data bits
    rreg(BPDB_OFF_DATA, 8'h35);
    rreg(BPDB_OFF_DIR, 8'h00);
    rreg(8'h07, 8'h00);
    $display("test 2 done");
    @(posedge clk);
    ewd <= 8'h5A;
    drv <= 1;
    wreg(BPDB_OFF_FUNC, 8'h01);
    chk({7'h00, bmode}, 8'h01);
    chk(pins, 8'h5A);
    chk(oe_b, 8'h00);
    @(posedge clk);
    drv <= 0;
    pat <= 8'hC3;
    @(posedge clk);
    #1 chk(oe_b, 8'hFF);
    repeat (3) @(posedge clk);
    #1 chk(erd, 8'hC3);
    // upper bits of the function byte carry no meaning
    wreg(BPDB_OFF_FUNC, 8'hFE);
    chk({7'h00, bmode}, 8'h00);
    chk(oe_b, 8'hF0);
    chk(pins & 8'h0F, 8'h05);
    $display("test 3 done");
    complete_run();
  end
endmodule : bpdb_port_tb
`default_nettype wire
